// *** hw/pdc_pkg.sv ***
// Constants, field positions and types shared by the power-state control block.
// Assumes a single 125 MHz system clock and byte-wide register access.
package pdc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV = 8'h3E;
  localparam logic [7:0] ADDR_DEV = 8'h3F;

  // ----------------------------------------------------------------
  // Converter control fields
  // ----------------------------------------------------------------
  localparam int POS_TRACK = 6;
  localparam int POS_PSKIP_CORE2 = 5;
  localparam int POS_PSKIP_CORE1 = 4;
  localparam int POS_PSKIP_IO = 3;
  localparam int POS_PAD_SEL = 2;
  localparam int POS_SYNC_HI = 1;
  localparam int POS_SYNC_LO = 0;
  localparam logic TRACK_RST = 1'b0;
  localparam logic PAD_SEL_RST = 1'b0;
  localparam logic [1:0] SYNC_RST = 2'h1;
  localparam logic [1:0] SYNC_PHASE = 2'h1;
  localparam logic [1:0] SYNC_PLAIN = 2'h3;

  // ----------------------------------------------------------------
  // Device state control fields
  // ----------------------------------------------------------------
  localparam int POS_SHUT_REV = 7;
  localparam int POS_CAL_DIS = 6;
  localparam int POS_SLOW_SEL = 5;
  localparam int POS_SCALE_PORT = 4;
  localparam int POS_OFF_CORERST = 3;
  localparam int POS_HOLD_ON = 2;
  localparam int POS_SLEEP_OK = 1;
  localparam int POS_OFF_REQ = 0;
  localparam logic SHUT_REV_RST = 1'b0;
  localparam logic CAL_DIS_RST = 1'b0;
  localparam logic SCALE_PORT_RST = 1'b1;
  localparam logic OFF_BIT_RST = 1'b0;

  // ----------------------------------------------------------------
  // Regulator four voltage codes (50 mV steps from 0.8 V)
  // ----------------------------------------------------------------
  localparam logic [5:0] SEL_NORM_MIN = 6'h04;
  localparam logic [5:0] SEL_NORM_MAX = 6'h32;
  localparam logic [5:0] SEL_TRACK_MIN = 6'h00;
  localparam logic [5:0] SEL_TRACK_MAX = 6'h0E;

  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int SLOT_TIME_US = 200;
  localparam int SLOT_CYCLES = SLOT_TIME_US * CLK_MHZ;
  localparam int NUM_RES = 8;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_UP = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_SLEEP = 3'b011,
    ST_DOWN = 3'b100
  } pdc_state_t;

endpackage : pdc_pkg

// *** hw/pdc_res_seq.sv ***
// Resource enable sequencer: turns resources on in order, and off either
// all at once or in reverse order, one per time slot.
// Assumes start pulses arrive only while the sequencer is idle.
`timescale 1ns/1ps
`default_nettype none
module pdc_res_seq
  import pdc_pkg::*;
#(
  parameter int N = NUM_RES,
  parameter int SLOT = SLOT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic upStart,
  input wire logic downStart,
  input wire logic reverse,
  output logic [N-1:0] resEnable,
  output logic seqDone
);

  localparam int IW = (N > 1) ? $clog2(N) : 1;
  localparam logic [IW-1:0] LAST = IW'(N - 1);

  logic busyReg;
  logic dirUpReg;
  logic [IW-1:0] idxReg;
  logic [31:0] slotReg;
  logic slotEnd;

  assign slotEnd = (slotReg == 32'(SLOT - 1));

  always_ff @(posedge clk_sys) begin
    if (rst || !busyReg || slotEnd) begin
      slotReg <= '0;
    end else begin
      slotReg <= slotReg + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    seqDone <= 1'b0;
    if (rst) begin
      busyReg <= 1'b0;
      dirUpReg <= 1'b1;
      idxReg <= '0;
      resEnable <= '0;
    end else if (upStart) begin
      busyReg <= 1'b1;
      dirUpReg <= 1'b1;
      idxReg <= '0;
      resEnable <= '0;
    end else if (downStart) begin
      if (reverse) begin
        busyReg <= 1'b1;
        dirUpReg <= 1'b0;
        idxReg <= LAST;
      end else begin
        resEnable <= '0;
        seqDone <= 1'b1;
      end
    end else if (busyReg && slotEnd) begin
      resEnable[idxReg] <= dirUpReg;
      if (dirUpReg ? (idxReg == LAST) : (idxReg == '0)) begin
        busyReg <= 1'b0;
        seqDone <= 1'b1;
      end else begin
        idxReg <= dirUpReg ? idxReg + IW'(1) : idxReg - IW'(1);
      end
    end
  end

  a_all_off_once: assert property (@(posedge clk_sys) disable iff (rst)
    (downStart && !reverse && !upStart) |=> (resEnable == '0) && seqDone)
    else $error("Simultaneous shutdown did not clear all enables.");

endmodule : pdc_res_seq
`default_nettype wire

// *** hw/pdc_state_ctrl.sv ***
// Converter control and device power-state control registers with the
// state machine they steer.
// Assumes register accesses are already decoded from the control serial
// port, and all inputs are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pdc_state_ctrl
  import pdc_pkg::*;
#(
  parameter int SLOT = SLOT_CYCLES,
  parameter int NRES = NUM_RES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic generalRst,
  input wire logic turnOffRst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  output logic [7:0] regRdData,
  input wire logic [2:0] bootPulseSkip,
  input wire logic bootHoldOn,
  input wire logic bootSlowClkSel,
  input wire logic powerOnEvent,
  input wire logic extOffEvent,
  input wire logic sleepSignal,
  input wire logic coreOneActive,
  input wire logic [5:0] regulatorFourSel,
  output pdc_state_t deviceState,
  output logic [NRES-1:0] resEnable,
  output logic coreReset,
  output logic regulatorFourTrack,
  output logic [5:0] regulatorFourSelEff,
  output logic core2PulseSkipEn,
  output logic core1PulseSkipEn,
  output logic ioRailPulseSkipEn,
  output logic generalPinTwoClkIn,
  output logic convSyncEn,
  output logic convPhaseShift,
  output logic calendarClkGate,
  output logic calendarReset,
  output logic slowClkSourceSel,
  output logic scalingPortSelect
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] pdcClamp(input logic [5:0] v, input logic [5:0] lo,
                                          input logic [5:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end else begin
      return v;
    end
  endfunction : pdcClamp

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [6:0] convReg;
  logic [7:0] devReg;
  pdc_state_t stateReg;
  pdc_state_t stateNext;
  logic wrConv;
  logic wrDev;
  logic offPend;
  logic seqUp;
  logic seqDown;
  logic seqDone;
  logic enterOff;
  logic offRstNow;
  logic coreRstReg;

  assign wrConv = regWrEn && (regAddr == ADDR_CONV);
  assign wrDev = regWrEn && (regAddr == ADDR_DEV);
  assign offPend = devReg[POS_OFF_REQ] || devReg[POS_OFF_CORERST];
  assign enterOff = (stateReg == ST_DOWN) && seqDone;
  // Reaching OFF fires the turn-off reset domain internally.
  assign offRstNow = turnOffRst || enterOff;

  // ----------------------------------------------------------------
  // Converter control register
  // ----------------------------------------------------------------
  // Writes are ordered after the domain resets, so a write that lands in
  // the same cycle as a domain reset is kept.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      convReg <= {TRACK_RST, bootPulseSkip, PAD_SEL_RST, SYNC_RST};
    end else begin
      if (offRstNow) begin
        convReg[POS_TRACK] <= TRACK_RST;
        convReg[POS_PSKIP_CORE2:POS_PSKIP_IO] <= bootPulseSkip;
      end
      if (generalRst) begin
        convReg[POS_PAD_SEL] <= PAD_SEL_RST;
        convReg[POS_SYNC_HI:POS_SYNC_LO] <= SYNC_RST;
      end
      if (wrConv) begin
        convReg <= regWrData[6:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Device state control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      devReg <= {SHUT_REV_RST, CAL_DIS_RST, bootSlowClkSel, SCALE_PORT_RST,
                 OFF_BIT_RST, bootHoldOn, OFF_BIT_RST, OFF_BIT_RST};
    end else begin
      if (offRstNow) begin
        devReg[POS_OFF_CORERST] <= OFF_BIT_RST;
        devReg[POS_SLEEP_OK] <= OFF_BIT_RST;
        devReg[POS_OFF_REQ] <= OFF_BIT_RST;
      end
      if (generalRst) begin
        devReg[POS_SHUT_REV] <= SHUT_REV_RST;
        devReg[POS_CAL_DIS] <= CAL_DIS_RST;
        devReg[POS_SLOW_SEL] <= bootSlowClkSel;
        devReg[POS_SCALE_PORT] <= SCALE_PORT_RST;
        devReg[POS_HOLD_ON] <= bootHoldOn;
      end
      if (wrDev) begin
        devReg <= regWrData;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regAddr == ADDR_CONV) begin
      regRdData <= {1'b0, convReg};
    end else if (regAddr == ADDR_DEV) begin
      regRdData <= devReg;
    end else begin
      regRdData <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;
    seqUp = 1'b0;
    seqDown = 1'b0;
    case (stateReg)
      ST_OFF: begin
        if (powerOnEvent) begin
          stateNext = ST_UP;
          seqUp = 1'b1;
        end
      end
      ST_UP: begin
        if (seqDone) begin
          stateNext = ST_ACTIVE;
        end
      end
      ST_ACTIVE, ST_SLEEP: begin
        if (offPend || (extOffEvent && !devReg[POS_HOLD_ON])) begin
          stateNext = ST_DOWN;
          seqDown = 1'b1;
        end else if (stateReg == ST_ACTIVE) begin
          if (devReg[POS_SLEEP_OK] && sleepSignal) begin
            stateNext = ST_SLEEP;
          end
        end else if (!devReg[POS_SLEEP_OK] || !sleepSignal) begin
          stateNext = ST_ACTIVE;
        end
      end
      ST_DOWN: begin
        if (seqDone) begin
          stateNext = ST_OFF;
        end
      end
      default: begin
        stateNext = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stateReg <= ST_OFF;
    end else begin
      stateReg <= stateNext;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || enterOff) begin
      coreRstReg <= 1'b0;
    end else if (seqDown && devReg[POS_OFF_CORERST]) begin
      coreRstReg <= 1'b1;
    end
  end

  pdc_res_seq #(
    .N(NRES),
    .SLOT(SLOT)
  ) u_seq (
    .clk_sys(clk_sys),
    .rst(rst),
    .upStart(seqUp),
    .downStart(seqDown),
    .reverse(devReg[POS_SHUT_REV]),
    .resEnable(resEnable),
    .seqDone(seqDone)
  );

  // ----------------------------------------------------------------
  // Registered control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regulatorFourTrack <= 1'b0;
      regulatorFourSelEff <= SEL_NORM_MIN;
    end else begin
      regulatorFourTrack <= convReg[POS_TRACK] && coreOneActive;
      regulatorFourSelEff <= convReg[POS_TRACK]
        ? pdcClamp(regulatorFourSel, SEL_TRACK_MIN, SEL_TRACK_MAX)
        : pdcClamp(regulatorFourSel, SEL_NORM_MIN, SEL_NORM_MAX);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      core2PulseSkipEn <= 1'b1;
      core1PulseSkipEn <= 1'b1;
      ioRailPulseSkipEn <= 1'b1;
      generalPinTwoClkIn <= PAD_SEL_RST;
      convSyncEn <= 1'b1;
      convPhaseShift <= 1'b1;
    end else begin
      core2PulseSkipEn <= convReg[POS_PSKIP_CORE2];
      core1PulseSkipEn <= convReg[POS_PSKIP_CORE1];
      ioRailPulseSkipEn <= convReg[POS_PSKIP_IO];
      generalPinTwoClkIn <= convReg[POS_PAD_SEL];
      case (convReg[POS_SYNC_HI:POS_SYNC_LO])
        SYNC_PHASE: begin
          convSyncEn <= 1'b1;
          convPhaseShift <= 1'b1;
        end
        SYNC_PLAIN: begin
          convSyncEn <= 1'b1;
          convPhaseShift <= 1'b0;
        end
        default: begin
          convSyncEn <= 1'b0;
          convPhaseShift <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      calendarClkGate <= CAL_DIS_RST;
      calendarReset <= CAL_DIS_RST;
      slowClkSourceSel <= 1'b0;
      scalingPortSelect <= SCALE_PORT_RST;
    end else begin
      calendarClkGate <= devReg[POS_CAL_DIS];
      calendarReset <= devReg[POS_CAL_DIS];
      slowClkSourceSel <= devReg[POS_SLOW_SEL];
      scalingPortSelect <= devReg[POS_SCALE_PORT];
    end
  end

  assign deviceState = stateReg;
  assign coreReset = coreRstReg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence sOffPending;
    ((stateReg == ST_ACTIVE) || (stateReg == ST_SLEEP)) && offPend;
  endsequence

  sequence sReachOff;
    (stateReg == ST_DOWN) && seqDone && !wrDev && !rst;
  endsequence

  a_track_follow: assert property (
    (convReg[POS_TRACK] && coreOneActive) |=> regulatorFourTrack)
    else $error("Regulator four did not follow core one.");

  a_pskip_boot: assert property (
    (turnOffRst && !wrConv) |=> ##1 (core1PulseSkipEn == $past(bootPulseSkip[1], 2)))
    else $error("Pulse-skip enable missed its boot value.");

  a_pad_select: assert property (
    wrConv |=> ##1 (generalPinTwoClkIn == $past(regWrData[POS_PAD_SEL], 2)))
    else $error("Pad select did not follow the write.");

  a_sync_decode: assert property (
    (convReg[1:0] == 2'h2) |=> (!convSyncEn && !convPhaseShift))
    else $error("Sync code two must give unsynchronised clocks.");

  a_conv_domains: assert property (
    (generalRst && !offRstNow && !wrConv) |=> (convReg[6:3] == $past(convReg[6:3])))
    else $error("General reset touched turn-off bits.");

  a_dev_domains: assert property (
    (turnOffRst && !generalRst && !wrDev) |=> (devReg[7:4] == $past(devReg[7:4])))
    else $error("Turn-off reset touched general bits.");

  a_cal_disable: assert property (
    devReg[POS_CAL_DIS] |=> (calendarClkGate && calendarReset))
    else $error("Calendar domain not disabled.");

  // The check runs on the first edge after release, because an attempt that
  // starts while rst is high is disabled.
  a_scale_port: assert property (
    $fell(rst) |-> scalingPortSelect)
    else $error("Scaling port select not one after reset.");

  a_core_reset: assert property (
    (sOffPending and devReg[POS_OFF_CORERST]) |=> ((stateReg == ST_DOWN) && coreReset))
    else $error("Off-with-reset did not reset the core.");

  a_off_clear: assert property (
    sReachOff |=> ((stateReg == ST_OFF) && !devReg[POS_OFF_REQ] && !devReg[POS_SLEEP_OK]))
    else $error("Off bits not cleared on reaching OFF.");

  a_wake_up: assert property (
    ((stateReg == ST_SLEEP) && !offPend && !devReg[POS_SLEEP_OK]
      && !(extOffEvent && !devReg[POS_HOLD_ON])) |=> (stateReg == ST_ACTIVE))
    else $error("Sleep allow at zero did not wake the device.");

  a_off_priority: assert property (
    (sOffPending and (devReg[POS_SLEEP_OK] && sleepSignal)) |=> (stateReg == ST_DOWN))
    else $error("Switch-off lost to a sleep request.");

  a_track_range: assert property (
    $past(convReg[POS_TRACK]) |-> (regulatorFourSelEff <= SEL_TRACK_MAX))
    else $error("Tracking range exceeded.");

endmodule : pdc_state_ctrl
`default_nettype wire

// *** testbench/pdc_host_model.sv ***
// Host side of the register port: byte writes and reads on request.
// Assumes the bench calls its tasks one at a time, off reset.
`timescale 1ns/1ps
`default_nettype none
module pdc_host_model (
  input wire logic clk_sys,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
  end

  // The strobe is held for exactly one sampling edge, then dropped.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask : wr_reg

  // Read data lags the address by one registered stage, so wait two edges.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    repeat (2) @(posedge clk_sys);
    #1;
    d = regRdData;
  endtask : rd_reg
endmodule : pdc_host_model
`default_nettype wire

// *** testbench/pmic_dcdc_and_device_state_control_tb_top.sv ***
// Self-checking bench for the converter and device state control block.
// Assumes a shortened time slot so that whole power sequences stay brief.
`timescale 1ns/1ps
`default_nettype none
module pmic_dcdc_and_device_state_control_tb_top
  import pdc_pkg::*;
;
  localparam int TB_SLOT = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic generalRst = 1'b0;
  logic turnOffRst = 1'b0;
  logic [2:0] bootPulseSkip = 3'b110;
  logic bootHoldOn = 1'b1;
  logic bootSlowClkSel = 1'b1;
  logic powerOnEvent = 1'b0;
  logic extOffEvent = 1'b0;
  logic sleepSignal = 1'b0;
  logic coreOneActive = 1'b1;
  logic [5:0] regulatorFourSel = 6'h20;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrEn;
  logic [7:0] regRdData;
  pdc_state_t deviceState;
  logic [7:0] resEnable;
  logic coreReset, regulatorFourTrack, core2PulseSkipEn, core1PulseSkipEn;
  logic ioRailPulseSkipEn, generalPinTwoClkIn, convSyncEn, convPhaseShift;
  logic calendarClkGate, calendarReset, slowClkSourceSel, scalingPortSelect;
  logic [5:0] regulatorFourSelEff;
  int num_errors = 0;
  int n_tests = 0;

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  pdc_host_model host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdData(regRdData));

  pdc_state_ctrl #(.SLOT(TB_SLOT), .NRES(8)) dut (.clk_sys(clk_sys), .rst(rst),
    .generalRst(generalRst), .turnOffRst(turnOffRst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData),
    .bootPulseSkip(bootPulseSkip), .bootHoldOn(bootHoldOn), .bootSlowClkSel(bootSlowClkSel),
    .powerOnEvent(powerOnEvent), .extOffEvent(extOffEvent), .sleepSignal(sleepSignal),
    .coreOneActive(coreOneActive), .regulatorFourSel(regulatorFourSel),
    .deviceState(deviceState), .resEnable(resEnable), .coreReset(coreReset),
    .regulatorFourTrack(regulatorFourTrack), .regulatorFourSelEff(regulatorFourSelEff),
    .core2PulseSkipEn(core2PulseSkipEn), .core1PulseSkipEn(core1PulseSkipEn),
    .ioRailPulseSkipEn(ioRailPulseSkipEn), .generalPinTwoClkIn(generalPinTwoClkIn),
    .convSyncEn(convSyncEn), .convPhaseShift(convPhaseShift),
    .calendarClkGate(calendarClkGate), .calendarReset(calendarReset),
    .slowClkSourceSel(slowClkSourceSel), .scalingPortSelect(scalingPortSelect));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check8

  task automatic check1(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : check1

  task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd_reg(a, d);
    check8(name, exp, d);
  endtask : rd_check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // One-cycle pulse: 0 general reset, 1 turn-off reset, 2 power-on, 3 external off.
  task automatic pulse(input int which);
    @(posedge clk_sys);
    case (which)
      0: generalRst <= 1'b1;
      1: turnOffRst <= 1'b1;
      2: powerOnEvent <= 1'b1;
      default: extOffEvent <= 1'b1;
    endcase
    @(posedge clk_sys);
    generalRst <= 1'b0;
    turnOffRst <= 1'b0;
    powerOnEvent <= 1'b0;
    extOffEvent <= 1'b0;
  endtask : pulse

  task automatic wait_state(input pdc_state_t s, input int lim);
    int k;
    k = 0;
    // Step off the launching edge so the state is settled when first read.
    #1;
    while (deviceState !== s && k < lim) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check8("deviceState", {5'h0, s}, {5'h0, deviceState});
  endtask : wait_state

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    rd_check("conv reset", ADDR_CONV, 8'h31);
    rd_check("dev reset", ADDR_DEV, 8'h34);
    rd_check("unmapped", 8'h3D, 8'h00);
    check1("convSyncEn", 1'b1, convSyncEn);
    check1("convPhaseShift", 1'b1, convPhaseShift);
    check1("scalingPortSelect", 1'b1, scalingPortSelect);
    check1("slowClkSourceSel", 1'b1, slowClkSourceSel);
    check8("resEnable", 8'h00, resEnable);
  endtask : test_reset_values

  task automatic test_conv_fields();
    logic [1:0] code;
    host.wr_reg(8'h3C, 8'hFF);
    rd_check("unmapped write", 8'h3C, 8'h00);
    for (int c = 0; c < 4; c++) begin
      code = c[1:0];
      host.wr_reg(ADDR_CONV, 8'hFC | {6'h00, code});
      tick(2);
      check1("convSyncEn", code[0], convSyncEn);
      check1("convPhaseShift", code == 2'h1, convPhaseShift);
      rd_check("conv readback", ADDR_CONV, 8'h7C | {6'h00, code});
    end
    check1("core2PulseSkipEn", 1'b1, core2PulseSkipEn);
    check1("generalPinTwoClkIn", 1'b1, generalPinTwoClkIn);
    check1("regulatorFourTrack", 1'b1, regulatorFourTrack);
    check8("selEff track", 8'h0E, {2'h0, regulatorFourSelEff});
    @(posedge clk_sys);
    regulatorFourSel <= 6'h3F;
    coreOneActive <= 1'b0;
    tick(2);
    check1("regulatorFourTrack", 1'b0, regulatorFourTrack);
    host.wr_reg(ADDR_CONV, 8'h01);
    tick(2);
    check1("regulatorFourTrack", 1'b0, regulatorFourTrack);
    check8("selEff normal", 8'h32, {2'h0, regulatorFourSelEff});
    check1("core1PulseSkipEn", 1'b0, core1PulseSkipEn);
    check1("ioRailPulseSkipEn", 1'b0, ioRailPulseSkipEn);
    check1("generalPinTwoClkIn", 1'b0, generalPinTwoClkIn);
  endtask : test_conv_fields

  task automatic test_domain_resets();
    host.wr_reg(ADDR_CONV, 8'h42);
    pulse(0);
    rd_check("conv general", ADDR_CONV, 8'h41);
    pulse(1);
    rd_check("conv turnoff", ADDR_CONV, 8'h31);
    host.wr_reg(ADDR_DEV, 8'hE0);
    tick(2);
    check1("calendarClkGate", 1'b1, calendarClkGate);
    check1("calendarReset", 1'b1, calendarReset);
    check1("scalingPortSelect", 1'b0, scalingPortSelect);
    pulse(1);
    rd_check("dev turnoff", ADDR_DEV, 8'hE0);
    pulse(0);
    rd_check("dev general", ADDR_DEV, 8'h34);
  endtask : test_domain_resets

  task automatic test_sleep_and_off();
    host.wr_reg(ADDR_DEV, 8'h14);
    pulse(2);
    wait_state(ST_ACTIVE, 100);
    check8("resEnable up", 8'hFF, resEnable);
    // Hold-on set, so an external switch-off must be ignored.
    pulse(3);
    tick(3);
    check8("deviceState", {5'h0, ST_ACTIVE}, {5'h0, deviceState});
    @(posedge clk_sys);
    sleepSignal <= 1'b1;
    host.wr_reg(ADDR_DEV, 8'h16);
    wait_state(ST_SLEEP, 6);
    host.wr_reg(ADDR_DEV, 8'h14);
    wait_state(ST_ACTIVE, 6);
    // Off and sleep-allow together with sleep asked for: off must win.
    host.wr_reg(ADDR_DEV, 8'h17);
    wait_state(ST_DOWN, 3);
    wait_state(ST_OFF, 6);
    check8("resEnable off", 8'h00, resEnable);
    rd_check("dev after off", ADDR_DEV, 8'h14);
    @(posedge clk_sys);
    sleepSignal <= 1'b0;
  endtask : test_sleep_and_off

  task automatic test_reverse_off();
    int k;
    host.wr_reg(ADDR_CONV, 8'h42);
    pulse(2);
    wait_state(ST_ACTIVE, 100);
    host.wr_reg(ADDR_DEV, 8'h9C);
    wait_state(ST_DOWN, 3);
    tick(1);
    check1("coreReset", 1'b1, coreReset);
    k = 0;
    while (resEnable === 8'hFF && k < 10) begin
      tick(1);
      k++;
    end
    check8("resEnable first off", 8'h7F, resEnable);
    wait_state(ST_OFF, 60);
    tick(2);
    check1("coreReset", 1'b0, coreReset);
    rd_check("dev after off", ADDR_DEV, 8'h94);
    rd_check("conv after off", ADDR_CONV, 8'h32);
  endtask : test_reverse_off

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    tick(2);
    test_reset_values();
    test_conv_fields();
    test_domain_resets();
    test_sleep_and_off();
    test_reverse_off();
    report_and_stop();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
endmodule : pmic_dcdc_and_device_state_control_tb_top
`default_nettype wire
